// ---- core/sfc_cmd_hold.sv ----
`timescale 1ns/10ps
`default_nettype none

// Keeps the last full opcode across frames and flags it by a toggle
module sfc_cmd_hold (
    input  wire logic       i_sclk,
    input  wire logic       i_rst,
    input  wire logic       i_load,
    input  wire logic [7:0] i_opc,
    output logic      [7:0] o_opc,
    output logic            o_tog
);

    sfc_pkg::sfc_hold_type hr_r;
    sfc_pkg::sfc_hold_type hr_nxt;

    always_comb begin
        hr_nxt = hr_r;
        if (i_load) begin
            hr_nxt.opc = i_opc;
            hr_nxt.tog = ~hr_r.tog;
        end
    end

    always_ff @(posedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            hr_r <= '0;
        end else begin
            hr_r <= hr_nxt;
        end
    end

    assign o_opc = hr_r.opc;
    assign o_tog = hr_r.tog;

endmodule : sfc_cmd_hold

`default_nettype wire

// ---- core/sfc_consts.svh ----
`ifndef SFC_CONSTS_SVH
`define SFC_CONSTS_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define SFC_OPC_STD_ID      8'h9f
`define SFC_OPC_LEGACY_SIG  8'hab
`define SFC_OPC_PAIR        8'h90
`define SFC_OPC_OTP_ENTER   8'hb1
`define SFC_OPC_OTP_EXIT    8'hc1
`define SFC_OPC_SEC_READ    8'h2b
`define SFC_OPC_SEC_LOCK    8'h2f
`define SFC_OPC_NO_OP       8'h00
`define SFC_OPC_RST_ARM     8'h66
`define SFC_OPC_RST_MEM     8'h99
`define SFC_OPC_WR_EN       8'h06
`define SFC_OPC_WR_DIS      8'h04
`define SFC_OPC_PAGE_PGM    8'h02
`define SFC_OPC_QUAD_PGM    8'h38
`define SFC_OPC_SECT_ERS    8'h20
`define SFC_OPC_HBLK_ERS    8'h52
`define SFC_OPC_BLK_ERS     8'hd8
`define SFC_OPC_CHIP_ERS_A  8'h60
`define SFC_OPC_CHIP_ERS_B  8'hc7
`define SFC_OPC_STAT_WR     8'h01

// ----------------------------------------------------------------
// Frame counts
// ----------------------------------------------------------------
`define SFC_BIT_LAST        3'h7
`define SFC_ARG_LAST        2'h2
`define SFC_STD_ID_LAST     5'h17
`define SFC_STD_MFR_BYTE    2'h0
`define SFC_STD_TYPE_BYTE   2'h1

`endif

// ---- core/sfc_pkg.sv ----
`default_nettype none

package sfc_pkg;

    typedef enum logic [3:0] {
        SFC_PH_OPC  = 4'h1,
        SFC_PH_ARG  = 4'h2,
        SFC_PH_OUT  = 4'h4,
        SFC_PH_IDLE = 4'h8
    } sfc_phase_type;

    typedef struct packed {
        sfc_phase_type phase;
        logic [7:0]    opc;
        logic [7:0]    sh;
        logic [2:0]    bcnt;
        logic [1:0]    bidx;
        logic [4:0]    ocnt;
        logic          order;
    } sfc_link_type;

    typedef struct packed {
        logic so;
        logic oe;
    } sfc_drive_type;

    typedef struct packed {
        logic [7:0] opc;
        logic       tog;
    } sfc_hold_type;

    typedef struct packed {
        logic       write_enable_latch;
        logic       otp;
        logic       lock;
        logic       arm;
        logic       pend;
        logic [7:0] opc;
        logic       tog;
        logic       cs_n_q;
        logic       soft_rst;
        logic       pe_go;
        logic [7:0] pe_opc;
    } sfc_sys_type;

endpackage : sfc_pkg

`default_nettype wire

// ---- core/sfc_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

module sfc_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);

    logic [W-1:0] meta_r;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_r <= '0;
            o_q    <= '0;
        end else begin
            meta_r <= i_d;
            o_q    <= meta_r;
        end
    end

endmodule : sfc_sync

`default_nettype wire

// ---- core/sfc_top.sv ----
// What this block does
// - Standard ID read returns three bytes, repeating while clocked
// - Standard ID ignored while program/erase runs
// - Chip select high returns device to standby
// - Signature repeats while clocked, host reads once
// - Address bit zero picks pair order
// - Pair bytes out on falling edge, MSB first
// - Pair bytes alternate until chip select high
// - Lock write sets lock until system reset, clears latch
// - Reset only directly after reset arm
// - Write enable sets the latch
// - Write disable clears the latch
// - Latch cleared by reset, suspend, completions
// - Upper data lines ignored for these commands
// - Program/erase ignored while latch clear
`timescale 1ns/10ps
`default_nettype none
`include "sfc_consts.svh"

module sfc_top #(
    parameter logic [7:0] MFR_ID      = 8'h5a, // Arbitrary value
    parameter logic [7:0] MEM_TYPE    = 8'h11, // Arbitrary value
    parameter logic [7:0] MEM_DENSITY = 8'h22, // Arbitrary value
    parameter logic [7:0] SIG_ID      = 8'h33, // Arbitrary value
    parameter logic [7:0] PAIR_DEV_ID = 8'h44  // Arbitrary value
) (
    // System clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    // Serial link
    input  wire logic       i_sclk,
    input  wire logic       i_cs_n,
    input  wire logic       i_si,
    output logic            o_so,
    output logic            o_so_oe,
    // Array engine
    input  wire logic       i_pe_busy,
    input  wire logic       i_pe_done,
    input  wire logic       i_pe_suspend,
    input  wire logic       i_rst_pin_n,
    output logic            o_pe_go,
    output logic      [7:0] o_pe_opc,
    // Mode and status
    output logic            o_wel,
    output logic            o_otp_mode,
    output logic            o_lock,
    output logic            o_soft_rst
);

    // ------------------------------------------------------------
    // Link side declarations
    // ------------------------------------------------------------
    sfc_pkg::sfc_link_type  lr_r;
    sfc_pkg::sfc_link_type  lr_nxt;
    sfc_pkg::sfc_drive_type dr_r;
    sfc_pkg::sfc_drive_type dr_nxt;

    logic       lrst;
    logic [7:0] din;
    logic       opc_load;
    logic       busy_l;
    logic [7:0] hold_opc;
    logic       hold_tog;
    logic [7:0] out_byte;

    // Frame state is wiped whenever chip select is high
    assign lrst = i_rst | i_cs_n;
    // Only the single input line is sampled
    assign din      = {lr_r.sh[6:0], i_si};
    assign opc_load = (lr_r.phase == sfc_pkg::SFC_PH_OPC) &&
                      (lr_r.bcnt == `SFC_BIT_LAST);

    sfc_sync #(
        .W   (1)
    ) u_busy_sync (
        .i_clk (i_sclk),
        .i_rst (i_rst),
        .i_d   (i_pe_busy),
        .o_q   (busy_l)
    );

    sfc_cmd_hold u_hold (
        .i_sclk (i_sclk),
        .i_rst  (i_rst),
        .i_load (opc_load),
        .i_opc  (din),
        .o_opc  (hold_opc),
        .o_tog  (hold_tog)
    );

    // ------------------------------------------------------------
    // Rising edge: opcode, arguments, output counter
    // ------------------------------------------------------------
    always_comb begin
        lr_nxt = lr_r;
        case (lr_r.phase)
            sfc_pkg::SFC_PH_OPC: begin
                lr_nxt.sh   = din;
                lr_nxt.bcnt = lr_r.bcnt + 3'h1;
                if (lr_r.bcnt == `SFC_BIT_LAST) begin
                    lr_nxt.opc = din;
                    case (din)
                        `SFC_OPC_STD_ID: begin
                            lr_nxt.phase = busy_l ?
                                sfc_pkg::SFC_PH_IDLE :
                                sfc_pkg::SFC_PH_OUT;
                        end
                        `SFC_OPC_LEGACY_SIG,
                        `SFC_OPC_PAIR: begin
                            lr_nxt.phase = sfc_pkg::SFC_PH_ARG;
                        end
                        default: begin
                            lr_nxt.phase = sfc_pkg::SFC_PH_IDLE;
                        end
                    endcase
                end
            end
            sfc_pkg::SFC_PH_ARG: begin
                lr_nxt.sh   = din;
                lr_nxt.bcnt = lr_r.bcnt + 3'h1;
                if (lr_r.bcnt == `SFC_BIT_LAST) begin
                    lr_nxt.bidx = lr_r.bidx + 2'h1;
                    if (lr_r.bidx == `SFC_ARG_LAST) begin
                        lr_nxt.phase = sfc_pkg::SFC_PH_OUT;
                        lr_nxt.order = din[0];
                    end
                end
            end
            sfc_pkg::SFC_PH_OUT: begin
                if ((lr_r.opc == `SFC_OPC_STD_ID) &&
                    (lr_r.ocnt == `SFC_STD_ID_LAST)) begin
                    lr_nxt.ocnt = 5'h0;
                end else begin
                    lr_nxt.ocnt = lr_r.ocnt + 5'h1;
                end
            end
            sfc_pkg::SFC_PH_IDLE: begin
                lr_nxt.ocnt = lr_r.ocnt;
            end
            default: begin
                lr_nxt.phase = sfc_pkg::SFC_PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sclk or posedge lrst) begin
        if (lrst) begin
            lr_r       <= '0;
            lr_r.phase <= sfc_pkg::SFC_PH_OPC;
        end else begin
            lr_r <= lr_nxt;
        end
    end

    // ------------------------------------------------------------
    // Falling edge: serial output
    // ------------------------------------------------------------
    always_comb begin
        case (lr_r.opc)
            `SFC_OPC_STD_ID: begin
                if (lr_r.ocnt[4:3] == `SFC_STD_MFR_BYTE) begin
                    out_byte = MFR_ID;
                end else if (lr_r.ocnt[4:3] == `SFC_STD_TYPE_BYTE) begin
                    out_byte = MEM_TYPE;
                end else begin
                    out_byte = MEM_DENSITY;
                end
            end
            `SFC_OPC_LEGACY_SIG: begin
                out_byte = SIG_ID;
            end
            default: begin
                out_byte = (lr_r.ocnt[3] ^ lr_r.order) ?
                           PAIR_DEV_ID : MFR_ID;
            end
        endcase
        dr_nxt.so = out_byte[~lr_r.ocnt[2:0]];
        dr_nxt.oe = (lr_r.phase == sfc_pkg::SFC_PH_OUT);
    end

    always_ff @(negedge i_sclk or posedge lrst) begin
        if (lrst) begin
            dr_r <= '0;
        end else begin
            dr_r <= dr_nxt;
        end
    end

    assign o_so    = dr_r.so;
    assign o_so_oe = dr_r.oe;

    // ------------------------------------------------------------
    // System side: command completion at chip select high
    // ------------------------------------------------------------
    sfc_pkg::sfc_sys_type sr_r;
    sfc_pkg::sfc_sys_type sr_nxt;

    logic [2:0] sync_q;
    logic       tog_s;
    logic       cs_n_s;
    logic       pin_n_s;
    logic       tog_edge;
    logic       done;
    logic [7:0] opc_cur;

    sfc_sync #(
        .W   (3)
    ) u_sys_sync (
        .i_clk (i_clk_sys),
        .i_rst (i_rst),
        .i_d   ({hold_tog, i_cs_n, i_rst_pin_n}),
        .o_q   (sync_q)
    );

    assign tog_s    = sync_q[2];
    assign cs_n_s   = sync_q[1];
    assign pin_n_s  = sync_q[0];
    assign tog_edge = (tog_s != sr_r.tog);
    // Held opcode is stable once its toggle has crossed
    assign opc_cur  = tog_edge ? hold_opc : sr_r.opc;
    assign done     = cs_n_s & ~sr_r.cs_n_q & (sr_r.pend | tog_edge);

    always_comb begin
        sr_nxt          = sr_r;
        sr_nxt.soft_rst = 1'b0;
        sr_nxt.pe_go    = 1'b0;
        sr_nxt.cs_n_q   = cs_n_s;
        if (tog_edge) begin
            sr_nxt.tog  = tog_s;
            sr_nxt.opc  = hold_opc;
            sr_nxt.pend = 1'b1;
        end
        if (i_pe_done || i_pe_suspend || !pin_n_s) begin
            sr_nxt.write_enable_latch = 1'b0;
        end
        if (done) begin
            sr_nxt.pend = 1'b0;
            sr_nxt.arm  = (opc_cur == `SFC_OPC_RST_ARM);
            case (opc_cur)
                `SFC_OPC_WR_EN: begin
                    sr_nxt.write_enable_latch = 1'b1;
                end
                `SFC_OPC_WR_DIS: begin
                    sr_nxt.write_enable_latch = 1'b0;
                end
                `SFC_OPC_OTP_ENTER: begin
                    sr_nxt.otp = 1'b1;
                end
                `SFC_OPC_OTP_EXIT: begin
                    sr_nxt.otp = 1'b0;
                end
                `SFC_OPC_SEC_LOCK: begin
                    sr_nxt.lock = 1'b1;
                    sr_nxt.write_enable_latch  = 1'b0;
                end
                `SFC_OPC_RST_MEM: begin
                    if (sr_r.arm) begin
                        sr_nxt.soft_rst = 1'b1;
                        sr_nxt.write_enable_latch      = 1'b0;
                        sr_nxt.otp      = 1'b0;
                    end
                end
                `SFC_OPC_PAGE_PGM,
                `SFC_OPC_QUAD_PGM,
                `SFC_OPC_SECT_ERS,
                `SFC_OPC_HBLK_ERS,
                `SFC_OPC_BLK_ERS,
                `SFC_OPC_CHIP_ERS_A,
                `SFC_OPC_CHIP_ERS_B,
                `SFC_OPC_STAT_WR: begin
                    if (sr_r.write_enable_latch && !i_pe_busy) begin
                        sr_nxt.pe_go  = 1'b1;
                        sr_nxt.pe_opc = opc_cur;
                    end
                end
                default: begin
                    sr_nxt.pend = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            sr_r <= '0;
        end else begin
            sr_r <= sr_nxt;
        end
    end

    assign o_wel      = sr_r.write_enable_latch;
    assign o_otp_mode = sr_r.otp;
    assign o_lock     = sr_r.lock;
    assign o_soft_rst = sr_r.soft_rst;
    assign o_pe_go    = sr_r.pe_go;
    assign o_pe_opc   = sr_r.pe_opc;

endmodule : sfc_top

`default_nettype wire

// ---- tb/sfc_host.sv ----
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Host serial controller model
// ----------------------------------------------------------------
module sfc_host (
    // Link pins
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_si,
    input  wire logic i_so,
    input  wire logic i_so_oe
);
    initial begin
        o_sclk = 1'b0;
        // Low at power-up so reset gives the link logic a clean edge
        o_cs_n = 1'b0;
        o_si   = 1'b0;
        #5 o_cs_n = 1'b1;
    end

    // Whole frame, clock only while selected
    task automatic xfer(input logic [31:0] tx, input int ntx, input int nrx,
                        output logic [63:0] rx, output int ndrv);
        logic ln;
        rx   = '0;
        ndrv = 0;
        ln   = 1'b0;
        #1.7 o_cs_n = 1'b0;
        for (int i = 0; i < ntx + nrx; i++) begin
            o_si = (i < ntx) ? tx[ntx-1-i] : ~o_si;
            #3 o_sclk = 1'b1;
            if (i >= ntx) begin
                ln   = i_so_oe ? i_so : ~ln;
                rx   = {rx[62:0], ln};
                ndrv = ndrv + int'(i_so_oe);
            end
            #3 o_sclk = 1'b0;
        end
        #3 o_cs_n = 1'b1;
        o_si = ~o_si;
        #200;
    endtask : xfer
endmodule : sfc_host

`default_nettype wire

// ---- tb/sfc_sva.sv ----
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module sfc_chk #(
    parameter logic [7:0] MFR_ID = 8'h5a
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic o_so,
    input wire logic o_so_oe,
    input wire logic i_pe_busy,
    input wire logic i_pe_done,
    input wire logic i_pe_suspend,
    input wire logic i_rst_pin_n,
    input wire logic o_pe_go,
    input wire logic o_wel,
    input wire logic o_otp_mode,
    input wire logic o_lock,
    input wire logic o_soft_rst
);
    logic [3:0] hi_cnt;
    logic [3:0] rcnt;
    logic [7:0] sh;
    logic [2:0] bq;

    // Sys cycles since chip select went high
    always_ff @(posedge i_clk_sys or posedge i_rst)
        if (i_rst) hi_cnt <= 4'h0;
        else if (!i_cs_n) hi_cnt <= 4'h0;
        else if (hi_cnt != 4'hf) hi_cnt <= hi_cnt + 4'h1;

    // Rising edges and opcode within a frame
    always_ff @(posedge i_sclk or posedge i_cs_n)
        if (i_cs_n) begin
            rcnt <= 4'h0;
            sh   <= 8'h00;
        end else begin
            if (rcnt != 4'hf) rcnt <= rcnt + 4'h1;
            if (rcnt < 4'h8) sh <= {sh[6:0], i_si};
        end

    always_ff @(posedge i_sclk)
        bq <= {bq[1:0], i_pe_busy};

    a_cs_quiet: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        i_cs_n |-> !o_so_oe && !o_so)
        else $error("output driven with cs high");
    a_opc_silent: assert property (
        @(posedge i_sclk) disable iff (i_rst || i_cs_n)
        rcnt < 4'h8 |-> !o_so_oe)
        else $error("output during opcode");
    a_id_first: assert property (
        @(posedge i_sclk) disable iff (i_rst || i_cs_n)
        rcnt == 4'h8 && sh == 8'h9f && bq == 3'h0 && !i_pe_busy
        |-> o_so_oe && o_so == MFR_ID[7])
        else $error("id read first bit wrong");
    a_id_refused: assert property (
        @(posedge i_sclk) disable iff (i_rst || i_cs_n)
        rcnt == 4'h8 && sh == 8'h9f && bq == 3'h7 && i_pe_busy
        |-> !o_so_oe)
        else $error("id read answered while busy");
    a_lock_sticky: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        o_lock |=> o_lock)
        else $error("lock bit cleared");
    a_go_needs_wel: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        o_pe_go |-> $past(o_wel))
        else $error("write op without latch");
    a_done_clears: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        hi_cnt >= 4'h6 && (i_pe_done || i_pe_suspend) |-> ##[1:2] !o_wel)
        else $error("latch kept after done or suspend");
    a_pin_clears: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        hi_cnt >= 4'h6 && !i_rst_pin_n |-> ##[1:4] !o_wel)
        else $error("latch kept under reset pin");
    a_soft_rst_wel: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        o_soft_rst |-> !o_wel && !o_otp_mode ##1 !o_soft_rst)
        else $error("soft reset effect wrong");
    a_quiet_stable: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        hi_cnt >= 4'h6 |=> $stable(o_otp_mode) && $stable(o_lock)
        && !o_pe_go && !o_soft_rst)
        else $error("state changed without command");

    c_id_read: cover property (@(posedge i_sclk) rcnt == 4'h8 && sh == 8'h9f);
    c_pe_go: cover property (@(posedge i_clk_sys) o_pe_go);
    c_soft_rst: cover property (@(posedge i_clk_sys) o_soft_rst);
endmodule : sfc_chk

bind sfc_top sfc_chk #(.MFR_ID(MFR_ID)) chk_u (.*);

`default_nettype wire

// ---- tb/sfc_top_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module sfc_top_tb;
    localparam logic [7:0] MFR = 8'h6b;
    localparam logic [7:0] TYP = 8'h1c;
    localparam logic [7:0] DEN = 8'h2d;
    localparam logic [7:0] SIG = 8'h3e;
    localparam logic [7:0] PDV = 8'h4f;
    logic clk = 1'b0;
    logic rst = 1'b0;
    logic busy = 1'b0;
    logic done = 1'b0;
    logic susp = 1'b0;
    logic pin_n = 1'b1;
    wire logic sclk, cs_n, si, so, so_oe, pe_go, write_enable_latch, otp, lock, srst;
    wire logic [7:0] pe_opc;
    logic [63:0] rx;
    logic [7:0]  ops [8] = '{8'h02, 8'h38, 8'h20, 8'h52,
                             8'hd8, 8'h60, 8'hc7, 8'h01};
    int nd, go_cnt = 0, srst_cnt = 0, n0;
    int mismatches = 0, samples_checked = 0;

    sfc_top #(.MFR_ID(MFR), .MEM_TYPE(TYP), .MEM_DENSITY(DEN),
              .SIG_ID(SIG), .PAIR_DEV_ID(PDV)) dut_u (
        .i_clk_sys(clk), .i_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_si(si), .o_so(so), .o_so_oe(so_oe), .i_pe_busy(busy),
        .i_pe_done(done), .i_pe_suspend(susp), .i_rst_pin_n(pin_n),
        .o_pe_go(pe_go), .o_pe_opc(pe_opc), .o_wel(write_enable_latch),
        .o_otp_mode(otp), .o_lock(lock), .o_soft_rst(srst));
    sfc_host host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si),
                     .i_so(so), .i_so_oe(so_oe));

    always #10 clk = ~clk;
    always @(negedge clk) begin
        go_cnt   = go_cnt + int'(pe_go);
        srst_cnt = srst_cnt + int'(srst);
    end

    task automatic chk(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic cmd(input logic [7:0] op);
        @(negedge clk);
        host_u.xfer({24'h0, op}, 8, 0, rx, nd);
    endtask : cmd

    task automatic pulse(ref logic s);
        @(negedge clk) s = ~s;
        @(negedge clk) s = ~s;
        repeat (6) @(negedge clk);
    endtask : pulse

    task automatic end_sim;
        $display("mismatches %0d samples_checked %0d", mismatches,
                 samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    task automatic t_ids;
        host_u.xfer(32'h9f, 8, 48, rx, nd);
        chk("id bytes", {MFR, TYP, DEN, MFR, TYP, DEN}, rx);
        chk("oe after cs", 0, so_oe);
        host_u.xfer(32'h9f, 8, 12, rx, nd);
        chk("id cut short", {MFR, TYP[7:4]}, rx);
        chk("oe after cut", 0, so_oe);
        @(negedge clk) busy = 1'b1;
        host_u.xfer(32'h9f, 8, 16, rx, nd);
        chk("id while busy", 0, nd);
        @(negedge clk) busy = 1'b0;
        host_u.xfer(32'hab000000, 32, 16, rx, nd);
        chk("signature", {SIG, SIG}, rx);
        for (int a = 0; a < 2; a++) begin
            host_u.xfer({8'h90, 16'h0, 7'h0, a[0]}, 32, 32, rx, nd);
            chk("pair", a ? {PDV, MFR, PDV, MFR} : {MFR, PDV, MFR, PDV},
                rx);
        end
        $display("t_ids done");
    endtask : t_ids

    task automatic t_wel;
        cmd(8'h06);
        chk("wel set", 1, write_enable_latch);
        cmd(8'h04);
        chk("wel clr", 0, write_enable_latch);
        cmd(8'h06);
        pulse(done);
        chk("wel done", 0, write_enable_latch);
        cmd(8'h06);
        pulse(susp);
        chk("wel susp", 0, write_enable_latch);
        cmd(8'h06);
        pulse(pin_n);
        chk("wel pin", 0, write_enable_latch);
        foreach (ops[i]) begin
            n0 = go_cnt;
            cmd(ops[i]);
            chk("no latch", n0, go_cnt);
            cmd(8'h06);
            cmd(ops[i]);
            chk("go", n0 + 1, go_cnt);
            chk("go opc", ops[i], pe_opc);
            pulse(done);
            chk("wel after", 0, write_enable_latch);
        end
        cmd(8'h06);
        @(negedge clk) busy = 1'b1;
        n0 = go_cnt;
        cmd(8'h02);
        chk("no go busy", n0, go_cnt);
        @(negedge clk) busy = 1'b0;
        pulse(done);
        chk("wel after busy", 0, write_enable_latch);
        $display("t_wel done");
    endtask : t_wel

    task automatic t_modes;
        cmd(8'hb1);
        chk("otp on", 1, otp);
        cmd(8'hc1);
        chk("otp off", 0, otp);
        cmd(8'h06);
        cmd(8'h2f);
        chk("lock", 2'b10, {lock, write_enable_latch});
        n0 = srst_cnt;
        cmd(8'h06);
        cmd(8'h66);
        cmd(8'h00);
        cmd(8'h99);
        chk("rst skipped", {n0, 1'b1}, {srst_cnt, write_enable_latch});
        cmd(8'hb1);
        cmd(8'h66);
        cmd(8'h99);
        chk("rst done", {n0 + 1, 3'b001},
            {srst_cnt, write_enable_latch, otp, lock});
        $display("t_modes done");
    endtask : t_modes

    initial begin
        #1 rst = 1'b1;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_ids();
        t_wel();
        t_modes();
        end_sim();
    end

    initial begin
        #200000;
        mismatches++;
        end_sim();
    end
endmodule : sfc_top_tb

`default_nettype wire
